// ---- bit_flag_pkg.sv ----
/*
 * Constants, opcode encoding and state layout for the bit and flag
 * instruction unit. Assumes a single AHB-Lite slave on the core clock.
 */
//
// Behaviour
// - rotate left via carry: carry to bit 0, bit 7 to carry, Z C N V
// - rotate right via carry: carry to bit 7, bit 0 to carry, Z C N V
// - bit store copies operand bit b into transfer flag, nothing else
// - bit load writes transfer flag into operand bit b, flags unchanged
// - carry force one or zero changes only the carry flag
// - overflow force one or zero changes only the overflow flag
// - sign force one or zero changes only the sign flag
// - half carry force one sets only the half carry flag
// - half carry force zero clears only the half carry flag
// - sleep takes one clock, keeps flags, pulses the sleep request
// - watchdog restart takes one clock, keeps flags, pulses the restart
package bit_flag_pkg;

    // register offsets, byte addresses
    localparam logic [7:0] A_OPERAND = 8'h00;
    localparam logic [7:0] A_STATUS  = 8'h04;
    localparam logic [7:0] A_COMMAND = 8'h08;
    localparam logic [7:0] A_INFO    = 8'h0C;

    // status flag positions
    localparam int F_C = 0;
    localparam int F_Z = 1;
    localparam int F_N = 2;
    localparam int F_V = 3;
    localparam int F_S = 4;
    localparam int F_H = 5;
    localparam int F_T = 6;
    localparam int F_I = 7;

    localparam logic [7:0] M_C = 8'h01 << F_C;
    localparam logic [7:0] M_V = 8'h01 << F_V;
    localparam logic [7:0] M_S = 8'h01 << F_S;
    localparam logic [7:0] M_H = 8'h01 << F_H;
    localparam logic [7:0] M_T = 8'h01 << F_T;

    // command word fields
    localparam int CMD_OP_LSB  = 0;
    localparam int CMD_OP_W    = 5;
    localparam int CMD_BIT_LSB = 8;
    localparam int CMD_BIT_W   = 3;
    localparam int CMD_W       = 16;

    // reset values
    localparam logic [7:0] RST_OPERAND = 8'h00;
    localparam logic [7:0] RST_FLAGS   = 8'h00;

    typedef enum logic [4:0] {
        no_operation         = 5'h00,
        rotate_left_carry    = 5'h01,
        rotate_right_carry   = 5'h02,
        arith_shift_right    = 5'h03,
        nibble_swap          = 5'h04,
        flag_set_by_index    = 5'h05,
        flag_clear_by_index  = 5'h06,
        bit_to_transfer_flag = 5'h07,
        transfer_flag_to_bit = 5'h08,
        carry_force_one      = 5'h09,
        carry_force_zero     = 5'h0A,
        negative_force_one   = 5'h0B,
        negative_force_zero  = 5'h0C,
        zero_force_one       = 5'h0D,
        zero_force_zero      = 5'h0E,
        global_irq_on        = 5'h0F,
        global_irq_off       = 5'h10,
        sign_force_one       = 5'h11,
        sign_force_zero      = 5'h12,
        overflow_force_one   = 5'h13,
        overflow_force_zero  = 5'h14,
        transfer_force_one   = 5'h15,
        transfer_force_zero  = 5'h16,
        half_carry_force_one = 5'h17,
        half_carry_force_zero = 5'h18,
        sleep_enter          = 5'h19,
        watchdog_restart     = 5'h1A
    } op_e;

    typedef struct packed {
        logic              sel;
        logic              wr;
        logic [7:0]        addr;
        logic [7:0]        operand;
        logic [7:0]        flags;
        logic [CMD_W-1:0]  cmd;
        logic [7:0]        count;
        logic              bad;
        logic              sleep;
        logic              wdt;
        logic [31:0]       rdata;
        logic              ready;
    } unit_state_s;

endpackage : bit_flag_pkg

// ---- bit_flag_instruction_unit.sv ----
/*
 * Bit manipulation, status flag and core control instruction unit.
 * Software loads the operand and status registers, then writes a command
 * word; the command executes in the clock that ends its data phase.
 * Assumes one AHB-Lite master, word transfers only, hready = hreadyout.
 */
// Added by the designer: register access over AHB-Lite and the register offsets.
`timescale 1ns/1ns
module bit_flag_instruction_unit
    import bit_flag_pkg::*;
(
    // clock and reset
    input  wire logic        hclk,
    input  wire logic        hresetn,
    // ahb-lite slave
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    // core side
    output logic      [7:0]  operand_value,
    output logic      [7:0]  status_flags,
    output logic             sleep_req,
    output logic             wdt_restart
);

    unit_state_s s_ff;
    unit_state_s nxt_s;

    logic                 cmd_go;
    logic                 addr_take;
    op_e                  op;
    logic [CMD_BIT_W-1:0] bsel;
    logic [4:0]           fdec;
    logic [7:0]           d;
    logic                 c_in;

    // flags after a shift: C from the bit shifted out, N from the new top
    // bit, V as N xor C; S and H are left as they were
    function automatic logic [7:0] shift_flags(input logic [7:0] f,
                                               input logic [7:0] res,
                                               input logic       cout);
        logic [7:0] r;
        r      = f;
        r[F_C] = cout;
        r[F_Z] = (res == 8'h00);
        r[F_N] = res[7];
        r[F_V] = res[7] ^ cout;
        return r;
    endfunction : shift_flags

    // dedicated flag forces: {hit, value, index}
    function automatic logic [4:0] flag_decode(input op_e o);
        unique case (o)
            carry_force_one:       return {2'b11, 3'(F_C)};
            carry_force_zero:      return {2'b10, 3'(F_C)};
            negative_force_one:    return {2'b11, 3'(F_N)};
            negative_force_zero:   return {2'b10, 3'(F_N)};
            zero_force_one:        return {2'b11, 3'(F_Z)};
            zero_force_zero:       return {2'b10, 3'(F_Z)};
            global_irq_on:         return {2'b11, 3'(F_I)};
            global_irq_off:        return {2'b10, 3'(F_I)};
            sign_force_one:        return {2'b11, 3'(F_S)};
            sign_force_zero:       return {2'b10, 3'(F_S)};
            overflow_force_one:    return {2'b11, 3'(F_V)};
            overflow_force_zero:   return {2'b10, 3'(F_V)};
            transfer_force_one:    return {2'b11, 3'(F_T)};
            transfer_force_zero:   return {2'b10, 3'(F_T)};
            half_carry_force_one:  return {2'b11, 3'(F_H)};
            half_carry_force_zero: return {2'b10, 3'(F_H)};
            default:               return 5'h00;
        endcase
    endfunction : flag_decode

    assign cmd_go    = s_ff.sel && s_ff.wr && (s_ff.addr == A_COMMAND);
    assign addr_take = hsel && hready && htrans[1];
    assign op        = op_e'(hwdata[CMD_OP_LSB +: CMD_OP_W]);
    assign bsel      = hwdata[CMD_BIT_LSB +: CMD_BIT_W];
    assign fdec      = flag_decode(op);
    assign d         = s_ff.operand;
    assign c_in      = s_ff.flags[F_C];

    always_comb begin
        nxt_s       = s_ff;
        nxt_s.sleep = 1'b0;
        nxt_s.wdt   = 1'b0;
        nxt_s.ready = 1'b1;
        // data phase: writes land here, every command finishes in this clock
        if (s_ff.sel && s_ff.wr) begin
            case (s_ff.addr)
                A_OPERAND: nxt_s.operand = hwdata[7:0];
                A_STATUS:  nxt_s.flags   = hwdata[7:0];
                A_COMMAND: begin
                    nxt_s.cmd   = hwdata[CMD_W-1:0];
                    nxt_s.count = s_ff.count + 8'h01;
                    nxt_s.bad   = 1'b0;
                end
                default: ;
            endcase
        end
        if (cmd_go) begin
            if (fdec[4]) begin
                nxt_s.flags[fdec[2:0]] = fdec[3];
            end
            case (op)
                rotate_left_carry: begin
                    nxt_s.operand = {d[6:0], c_in};
                    nxt_s.flags = shift_flags(s_ff.flags, {d[6:0], c_in}, d[7]);
                end
                rotate_right_carry: begin
                    nxt_s.operand = {c_in, d[7:1]};
                    nxt_s.flags = shift_flags(s_ff.flags, {c_in, d[7:1]}, d[0]);
                end
                arith_shift_right: begin
                    nxt_s.operand = {d[7], d[7:1]};
                    nxt_s.flags = shift_flags(s_ff.flags, {d[7], d[7:1]}, d[0]);
                end
                nibble_swap: nxt_s.operand = {d[3:0], d[7:4]};
                flag_set_by_index:   nxt_s.flags[bsel] = 1'b1;
                flag_clear_by_index: nxt_s.flags[bsel] = 1'b0;
                bit_to_transfer_flag: nxt_s.flags[F_T] = d[bsel];
                transfer_flag_to_bit: begin
                    nxt_s.operand[bsel] = s_ff.flags[F_T];
                end
                sleep_enter:      nxt_s.sleep = 1'b1;
                watchdog_restart: nxt_s.wdt   = 1'b1;
                no_operation: ;
                default: nxt_s.bad = ~fdec[4];
            endcase
        end
        // address phase
        nxt_s.sel  = addr_take;
        nxt_s.wr   = hwrite;
        nxt_s.addr = haddr[7:0];
        // read data from the next state, so a read right behind a write or
        // a command sees the updated value without a wait state
        nxt_s.rdata = 32'h0000_0000;
        if (addr_take && !hwrite) begin
            case (haddr[7:0])
                A_OPERAND: nxt_s.rdata = {24'h00_0000, nxt_s.operand};
                A_STATUS:  nxt_s.rdata = {24'h00_0000, nxt_s.flags};
                A_COMMAND: nxt_s.rdata = {16'h0000, nxt_s.cmd};
                A_INFO:    nxt_s.rdata = {23'h00_0000, nxt_s.bad,
                                          nxt_s.count};
                default:   nxt_s.rdata = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            s_ff <= '{sel: 1'b0, wr: 1'b0, addr: 8'h00,
                      operand: RST_OPERAND, flags: RST_FLAGS,
                      cmd: 16'h0000, count: 8'h00, bad: 1'b0,
                      sleep: 1'b0, wdt: 1'b0, rdata: 32'h0000_0000,
                      ready: 1'b1};
        end else begin
            s_ff <= nxt_s;
        end
    end

    assign hrdata        = s_ff.rdata;
    assign hreadyout     = s_ff.ready;
    assign hresp         = 1'b0;
    assign operand_value = s_ff.operand;
    assign status_flags  = s_ff.flags;
    assign sleep_req     = s_ff.sleep;
    assign wdt_restart   = s_ff.wdt;

    // checks: each command's effect is visible one clock after its data phase

    AST_ROTATE_LEFT: assert property (
        @(posedge hclk) disable iff (!hresetn)
        cmd_go && op == rotate_left_carry |=>
            operand_value == {$past(operand_value[6:0]),
                              $past(status_flags[F_C])}
            && status_flags[F_C] == $past(operand_value[7])
            && status_flags[F_Z] == (operand_value == 8'h00)
            && status_flags[F_N] == operand_value[7]
            && status_flags[F_V] == (status_flags[F_N] ^ status_flags[F_C])
            && (status_flags & (M_S | M_H))
               == ($past(status_flags) & (M_S | M_H)))
        else $error("rotate left result or flags wrong");

    AST_ROTATE_RIGHT: assert property (
        @(posedge hclk) disable iff (!hresetn)
        cmd_go && op == rotate_right_carry |=>
            operand_value == {$past(status_flags[F_C]),
                              $past(operand_value[7:1])}
            && status_flags[F_C] == $past(operand_value[0])
            && status_flags[F_Z] == (operand_value == 8'h00)
            && status_flags[F_N] == operand_value[7]
            && status_flags[F_V] == (status_flags[F_N] ^ status_flags[F_C])
            && (status_flags & (M_S | M_H))
               == ($past(status_flags) & (M_S | M_H)))
        else $error("rotate right result or flags wrong");

    AST_BIT_STORE: assert property (
        @(posedge hclk) disable iff (!hresetn)
        cmd_go && op == bit_to_transfer_flag |=>
            status_flags[F_T] == $past(operand_value[bsel])
            && (status_flags & ~M_T) == ($past(status_flags) & ~M_T)
            && $stable(operand_value))
        else $error("bit store moved wrong bit or other flags");

    AST_BIT_LOAD: assert property (
        @(posedge hclk) disable iff (!hresetn)
        cmd_go && op == transfer_flag_to_bit |=>
            operand_value[$past(bsel)] == status_flags[F_T]
            && $stable(status_flags)
            && $countones(operand_value ^ $past(operand_value)) <= 1)
        else $error("bit load touched flags or other bits");

    AST_CARRY_FORCE: assert property (
        @(posedge hclk) disable iff (!hresetn)
        cmd_go && (op == carry_force_one || op == carry_force_zero) |=>
            status_flags[F_C] == ($past(op) == carry_force_one)
            && (status_flags & ~M_C) == ($past(status_flags) & ~M_C))
        else $error("carry force wrong");

    AST_OVERFLOW_FORCE: assert property (
        @(posedge hclk) disable iff (!hresetn)
        cmd_go && (op == overflow_force_one || op == overflow_force_zero) |=>
            status_flags[F_V] == ($past(op) == overflow_force_one)
            && (status_flags & ~M_V) == ($past(status_flags) & ~M_V))
        else $error("overflow force wrong");

    AST_SIGN_FORCE: assert property (
        @(posedge hclk) disable iff (!hresetn)
        cmd_go && (op == sign_force_one || op == sign_force_zero) |=>
            status_flags[F_S] == ($past(op) == sign_force_one)
            && (status_flags & ~M_S) == ($past(status_flags) & ~M_S))
        else $error("sign force wrong");

    AST_HALF_SET: assert property (
        @(posedge hclk) disable iff (!hresetn)
        cmd_go && op == half_carry_force_one |=>
            status_flags == ($past(status_flags) | M_H))
        else $error("half carry set wrong");

    AST_HALF_CLEAR: assert property (
        @(posedge hclk) disable iff (!hresetn)
        cmd_go && op == half_carry_force_zero |=>
            status_flags == ($past(status_flags) & ~M_H))
        else $error("half carry clear wrong");

    // a second sleep command right behind the first legally stretches it
    AST_SLEEP_PULSE: assert property (
        @(posedge hclk) disable iff (!hresetn)
        cmd_go && op == sleep_enter |=>
            sleep_req && $stable(status_flags)
            ##1 sleep_req == $past(cmd_go && op == sleep_enter))
        else $error("sleep request not a one clock pulse");

    AST_SLEEP_CAUSE: assert property (
        @(posedge hclk) disable iff (!hresetn)
        sleep_req |-> $past(cmd_go && op == sleep_enter))
        else $error("sleep request without a sleep command");

    AST_WATCHDOG_PULSE: assert property (
        @(posedge hclk) disable iff (!hresetn)
        cmd_go && op == watchdog_restart |=>
            wdt_restart && $stable(status_flags)
            ##1 wdt_restart == $past(cmd_go && op == watchdog_restart))
        else $error("watchdog restart not a one clock pulse");

    AST_WATCHDOG_CAUSE: assert property (
        @(posedge hclk) disable iff (!hresetn)
        wdt_restart |-> $past(cmd_go && op == watchdog_restart))
        else $error("watchdog restart without a restart command");

    AST_ARITH_SHIFT: assert property (
        @(posedge hclk) disable iff (!hresetn)
        cmd_go && op == arith_shift_right |=>
            operand_value == {$past(operand_value[7]),
                              $past(operand_value[7:1])}
            && status_flags[F_C] == $past(operand_value[0])
            && status_flags[F_Z] == (operand_value == 8'h00)
            && status_flags[F_N] == operand_value[7]
            && status_flags[F_V] == (status_flags[F_N] ^ status_flags[F_C])
            && (status_flags & (M_S | M_H))
               == ($past(status_flags) & (M_S | M_H)))
        else $error("arithmetic shift wrong");

    AST_SWAP_FLAGS: assert property (
        @(posedge hclk) disable iff (!hresetn)
        cmd_go && op == nibble_swap |=>
            operand_value == {$past(operand_value[3:0]),
                              $past(operand_value[7:4])}
            && $stable(status_flags))
        else $error("nibble swap wrong or flags changed");

    AST_INDEXED_FLAG: assert property (
        @(posedge hclk) disable iff (!hresetn)
        cmd_go && op == flag_set_by_index |=>
            status_flags == ($past(status_flags) | (8'h01 << $past(bsel))))
        else $error("indexed flag set wrong");

    AST_INDEXED_CLEAR: assert property (
        @(posedge hclk) disable iff (!hresetn)
        cmd_go && op == flag_clear_by_index |=>
            status_flags == ($past(status_flags) & ~(8'h01 << $past(bsel))))
        else $error("indexed flag clear wrong");

    AST_NEGATIVE_FORCE: assert property (
        @(posedge hclk) disable iff (!hresetn)
        cmd_go && (op == negative_force_one || op == negative_force_zero) |=>
            status_flags[F_N] == ($past(op) == negative_force_one)
            && ((status_flags ^ $past(status_flags))
                & ~(8'h01 << F_N)) == 8'h00)
        else $error("negative force wrong");

    AST_ZERO_FORCE: assert property (
        @(posedge hclk) disable iff (!hresetn)
        cmd_go && (op == zero_force_one || op == zero_force_zero) |=>
            status_flags[F_Z] == ($past(op) == zero_force_one)
            && ((status_flags ^ $past(status_flags))
                & ~(8'h01 << F_Z)) == 8'h00)
        else $error("zero force wrong");

    AST_NOP_QUIET: assert property (
        @(posedge hclk) disable iff (!hresetn)
        cmd_go && op == no_operation |=>
            $stable(status_flags) && $stable(operand_value)
            && !sleep_req && !wdt_restart)
        else $error("no-operation changed state");

    // codes past the last defined one must leave the datapath untouched
    AST_UNKNOWN_CODE: assert property (
        @(posedge hclk) disable iff (!hresetn)
        cmd_go && hwdata[CMD_OP_LSB +: CMD_OP_W] > 5'(watchdog_restart) |=>
            $stable(status_flags) && $stable(operand_value)
            && s_ff.bad && !sleep_req && !wdt_restart)
        else $error("unknown code changed state or was not flagged");

    AST_COMMAND_COUNT: assert property (
        @(posedge hclk) disable iff (!hresetn)
        cmd_go |=> s_ff.count == $past(s_ff.count) + 8'h01)
        else $error("command count did not advance by one");

    AST_READ_IDLE: assert property (
        @(posedge hclk) disable iff (!hresetn)
        !(addr_take && !hwrite) |=> hrdata == 32'h0000_0000)
        else $error("read data left standing outside its data phase");

    AST_ZERO_WAIT: assert property (
        @(posedge hclk) disable iff (!hresetn)
        hreadyout && !hresp)
        else $error("slave must answer okay with no wait");

endmodule : bit_flag_instruction_unit

// ---- bit_flag_instruction_unit_tb.sv ----
/*
 * Self-checking testbench for the bit and flag instruction unit.
 * Assumes the unit is the only AHB-Lite slave, hready = hreadyout,
 * and a 50 MHz hclk made here; all stimulus lands on rising edges.
 */
`timescale 1ns/1ns
module bit_flag_instruction_unit_tb
    import bit_flag_pkg::*;
;
    logic        hclk;
    logic        hresetn;
    logic        hsel;
    logic [31:0] haddr;
    logic [1:0]  htrans;
    logic        hwrite;
    logic [2:0]  hsize;
    logic [31:0] hwdata;
    logic [31:0] hrdata;
    logic        hreadyout;
    logic        hresp;
    logic [7:0]  operand_value;
    logic [7:0]  status_flags;
    logic        sleep_req;
    logic        wdt_restart;
    int          n_fail;
    int          comparisons;

    bit_flag_instruction_unit u_bit_flag_instruction_unit (
        .hclk          (hclk),
        .hresetn       (hresetn),
        .hsel          (hsel),
        .haddr         (haddr),
        .htrans        (htrans),
        .hwrite        (hwrite),
        .hsize         (hsize),
        .hwdata        (hwdata),
        .hready        (hreadyout),
        .hrdata        (hrdata),
        .hreadyout     (hreadyout),
        .hresp         (hresp),
        .operand_value (operand_value),
        .status_flags  (status_flags),
        .sleep_req     (sleep_req),
        .wdt_restart   (wdt_restart)
    );

    initial begin
        hclk = 1'b0;
        forever #10 hclk = ~hclk;
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_fail++;
            $display("CHECK FAILED t=%0t seen=%h expected=%h",
                     $time, seen, exp);
        end
    endtask : check

    task automatic give_verdict();
        $display("comparisons=%0d n_fail=%0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : give_verdict

    // called just after a rising edge; returns just after the data edge
    task automatic ahb_xfer(input logic wr, input logic [7:0] a,
                            input logic [31:0] wd, output logic [31:0] rd);
        hsel   <= 1'b1;
        haddr  <= {24'h000000, a};
        htrans <= 2'b10;
        hwrite <= wr;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel   <= 1'b0;
        htrans <= 2'b00;
        hwdata <= wr ? wd : 32'h00000000;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask : ahb_xfer

    task automatic wr32(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] unused;
        ahb_xfer(1'b1, a, d, unused);
    endtask : wr32

    task automatic rd32(input logic [7:0] a, output logic [31:0] d);
        ahb_xfer(1'b0, a, 32'h00000000, d);
    endtask : rd32

    // reference behaviour, returns {operand, flags}
    function automatic logic [15:0] model(input logic [4:0] op,
        input logic [2:0] b, input logic [7:0] d, input logic [7:0] f);
        int         pos [8] = '{F_C, F_N, F_Z, F_I, F_S, F_V, F_T, F_H};
        logic [7:0] r;
        logic [7:0] g;
        logic       sh;
        logic       c;
        r  = d;
        g  = f;
        sh = 1'b0;
        c  = f[F_C];
        case (op)
            5'h01: begin r = {d[6:0], f[F_C]}; c = d[7]; sh = 1'b1; end
            5'h02: begin r = {f[F_C], d[7:1]}; c = d[0]; sh = 1'b1; end
            5'h03: begin r = {d[7], d[7:1]}; c = d[0]; sh = 1'b1; end
            5'h04: r = {d[3:0], d[7:4]};
            5'h05: g[b] = 1'b1;
            5'h06: g[b] = 1'b0;
            5'h07: g[F_T] = d[b];
            5'h08: r[b] = f[F_T];
            default: begin
                // odd codes force one, even codes force zero
                if (op >= 5'h09 && op <= 5'h18)
                    g[pos[(op - 5'h09) >> 1]] = op[0];
            end
        endcase
        if (sh) begin
            g[F_C] = c;
            g[F_Z] = (r == 8'h00);
            g[F_N] = r[7];
            g[F_V] = r[7] ^ c;
        end
        return {r, g};
    endfunction : model

    initial begin
        repeat (20000) @(posedge hclk);
        n_fail++;
        give_verdict();
    end

    initial begin
        logic [7:0]  opd [3] = '{8'hB4, 8'h01, 8'h80};
        logic [7:0]  fl  [3] = '{8'h5A, 8'hA5, 8'h00};
        logic [31:0] d;
        logic [31:0] cmd;
        logic [15:0] exp;
        logic [4:0]  op;
        logic [2:0]  b;
        logic [7:0]  n_cmd;
        hresetn = 1'b0;
        hsel   = 1'b0;
        haddr  = 32'h00000000;
        htrans = 2'b00;
        hwrite = 1'b0;
        hsize  = 3'h2;
        hwdata = 32'h00000000;
        n_cmd  = 8'h00;
        cmd    = 32'h00000000;
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        #1;
        check({15'h0000, operand_value, status_flags, hresp},
              {15'h0000, RST_OPERAND, RST_FLAGS, 1'b0});
        check({30'h0, sleep_req, wdt_restart}, 32'h00000000);
        @(posedge hclk);
        rd32(A_INFO, d);
        check(d, 32'h00000000);
        // upper bits are dropped, unmapped offsets read zero
        wr32(A_OPERAND, 32'hFFFFFF3C);
        wr32(8'h10, 32'hFFFFFFFF);
        rd32(8'h10, d);
        check(d, 32'h00000000);
        rd32(A_OPERAND, d);
        check(d, 32'h0000003C);
        for (int v = 0; v < 3; v++) begin
            for (int k = 0; k < 28; k++) begin
                op  = 5'(k);
                b   = 3'(k + v);
                cmd = {21'h000000, b, 3'h0, op};
                wr32(A_OPERAND, {24'h000000, opd[v]});
                wr32(A_STATUS, {24'h000000, fl[v]});
                wr32(A_COMMAND, cmd);
                n_cmd++;
                exp = model(op, b, opd[v], fl[v]);
                #1;
                check({24'h0, operand_value}, {24'h0, exp[15:8]});
                check({24'h0, status_flags}, {24'h0, exp[7:0]});
                check({30'h0, sleep_req, wdt_restart},
                      {30'h0, op == 5'h19, op == 5'h1A});
                @(posedge hclk);
                #1;
                check({30'h0, sleep_req, wdt_restart}, 32'h0);
                check({24'h0, status_flags}, {24'h0, exp[7:0]});
                @(posedge hclk);
                rd32(A_INFO, d);
                check(d, {23'h000000, op > 5'h1A, n_cmd});
            end
        end
        rd32(A_COMMAND, d);
        check(d, {16'h0000, cmd[15:0]});
        rd32(A_STATUS, d);
        check(d, {24'h000000, exp[7:0]});
        check({30'h0, hreadyout, hresp}, 32'h2);
        give_verdict();
    end
endmodule : bit_flag_instruction_unit_tb
